// file: scbc_cfg.svh
// Constants for the SDRAM clock-enable and bank state control block
`ifndef SCBC_CFG_SVH
`define SCBC_CFG_SVH
`define SCBC_CLK_MHZ 25
`define SCBC_ROW_CYCLE_NS 70
`define SCBC_ROW_CYCLE_CYC ((`SCBC_ROW_CYCLE_NS * `SCBC_CLK_MHZ + 999) / 1000)
`define SCBC_BANK_BIT 11
`define SCBC_AP_BIT 10
`define SCBC_COL_BITS 8
`define SCBC_ROW_BITS 11
`define SCBC_MRS_WAIT 2
`endif

// file: scbc_ctrl.sv
// Clock-enable power state and two-bank state tracking for an SDRAM
// Notes on behaviour
// R01 - Clock enable rising wakes inputs from self-refresh or power-down; low keeps it there
// R02 - Recovery with enable high and deselect or nop goes idle after row cycle time
// R03 - Recovery with enable falling and deselect or nop enters power-down next cycle
// R04 - Power-down left to idle when enable sampled low then high
// R05 - Both idle, refresh code with enable falling enters self-refresh
// R06 - Both idle, enable high twice: nop, activate/precharge, auto-refresh, mode set
// R07 - Other states with enable high twice decode normal bank commands
// R08 - Non-idle state, enable falling freezes operation from next cycle
// R09 - Enable rising in suspend resumes operation on following cycle
// R10 - Controller presents a defined command when lowering enable for suspend
// R11 - Controller honours enable setup time before commands after wake
// R12 - Each bank is idle, active, read, write, read-ap or write-ap; nop keeps
// R13 - Read: bank bit picks bank, ap bit picks auto-precharge; other burst ends
// R14 - Write: same selection; other bank burst cut back to row active
// R15 - Activate moves chosen idle bank to active, latching row address
// R16 - Precharge all idles both; single idles chosen; burst stop ends bursts without auto-precharge
// R17 - Column address taken from low pins only, ignoring address bits 8 and 9
// R18 - Controller issues mode set only with both idle, waits two cycles
// R19 - Controller keeps its own bank model; the host model checks only mode set against it, other commands pass unchecked
`timescale 1ns/100ps
`default_nettype none
`include "scbc_cfg.svh"
module scbc_ctrl
#(
  parameter int ROW_WAIT = `SCBC_ROW_CYCLE_CYC
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cke,
  input wire scbc_pkg::scbc_cmd_s cmd,
  output logic [1:0] bank_idle,
  output logic [1:0] bank_active,
  output logic [1:0] bank_reading,
  output logic [1:0] bank_writing,
  output logic [1:0] bank_autoprecharge,
  output logic self_refresh,
  output logic power_down,
  output logic clock_suspended,
  output logic mode_set_pulse,
  output logic illegal_cmd,
  output logic [`SCBC_ROW_BITS-1:0] row_addr [2],
  output logic [`SCBC_COL_BITS-1:0] col_addr
);
  logic cke_prev_ff;
  logic [3:0] rc_cnt_ff;
  scbc_pkg::scbc_pwr_e pwr_ff;
  scbc_pkg::scbc_bank_e bank_ff [2];
  logic is_nop, is_act, is_rd, is_wr, is_pre, is_ref, is_mrs, is_bst, both_idle, run;
  logic is_quiet;
  logic sel;

  // Command decode from the pin group
  assign is_nop = cmd.cs_n | (cmd.ras_n & cmd.cas_n & cmd.we_n);
  assign is_bst = !cmd.cs_n & cmd.ras_n & cmd.cas_n & !cmd.we_n;
  assign is_rd = !cmd.cs_n & cmd.ras_n & !cmd.cas_n & cmd.we_n;
  assign is_wr = !cmd.cs_n & cmd.ras_n & !cmd.cas_n & !cmd.we_n;
  assign is_act = !cmd.cs_n & !cmd.ras_n & cmd.cas_n & cmd.we_n;
  assign is_pre = !cmd.cs_n & !cmd.ras_n & cmd.cas_n & !cmd.we_n;
  assign is_ref = !cmd.cs_n & !cmd.ras_n & !cmd.cas_n & cmd.we_n;
  assign is_mrs = !cmd.cs_n & !cmd.ras_n & !cmd.cas_n & !cmd.we_n;
  assign is_quiet = cmd.cs_n | (cmd.ras_n & cmd.cas_n); // Write-enable ignored around recovery
  assign sel = cmd.addr[`SCBC_BANK_BIT];
  assign both_idle = (bank_ff[0] == scbc_pkg::BANK_IDLE) && (bank_ff[1] == scbc_pkg::BANK_IDLE);
  // Commands act only with enable high in both sampled cycles and no low-power mode
  assign run = (pwr_ff == scbc_pkg::PWR_NORMAL) && cke_prev_ff && cke; // see R07

  // Previous-cycle enable sample; the wake itself is the synchronous edge
  // here, since the pad-level asynchronous wake sits outside this logic
  always_ff @(posedge clock)
  begin
    if (srst)
      cke_prev_ff <= 1'b0;
    else
      cke_prev_ff <= cke;
  end

  // Power state sequencing
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pwr_ff <= scbc_pkg::PWR_NORMAL;
      rc_cnt_ff <= 4'h0;
    end
    else
    begin
      case (pwr_ff)
        scbc_pkg::PWR_NORMAL:
        begin
          if (cke_prev_ff && !cke)
          begin
            if (both_idle && is_ref)
              pwr_ff <= scbc_pkg::PWR_SELF_REFRESH; // see R05
            else if (both_idle)
              pwr_ff <= scbc_pkg::PWR_POWER_DOWN; // see R05
            else
              pwr_ff <= scbc_pkg::PWR_SUSPEND; // see R08
          end
        end
        scbc_pkg::PWR_SELF_REFRESH:
        begin
          if (!cke_prev_ff && cke)
          begin
            pwr_ff <= scbc_pkg::PWR_SR_RECOVERY; // see R01
            rc_cnt_ff <= 4'(ROW_WAIT);
          end
        end
        scbc_pkg::PWR_SR_RECOVERY:
        begin
          if (cke_prev_ff && !cke && is_quiet)
            pwr_ff <= scbc_pkg::PWR_POWER_DOWN; // see R03
          else if (cke_prev_ff && cke && is_quiet)
          begin
            if (rc_cnt_ff <= 4'h1)
              pwr_ff <= scbc_pkg::PWR_NORMAL; // see R02
            else
              rc_cnt_ff <= rc_cnt_ff - 4'h1;
          end
        end
        scbc_pkg::PWR_POWER_DOWN:
        begin
          if (!cke_prev_ff && cke)
            pwr_ff <= scbc_pkg::PWR_NORMAL; // see R04
        end
        scbc_pkg::PWR_SUSPEND:
        begin
          if (cke)
            pwr_ff <= scbc_pkg::PWR_NORMAL; // see R09
        end
        default:
          pwr_ff <= scbc_pkg::PWR_NORMAL;
      endcase
    end
  end

  // Illegal command flag; one cycle, registered
  always_ff @(posedge clock)
  begin
    if (srst)
      illegal_cmd <= 1'b0;
    else if (pwr_ff == scbc_pkg::PWR_SELF_REFRESH)
      illegal_cmd <= !cke_prev_ff && cke && !is_quiet; // see R02
    else if (pwr_ff == scbc_pkg::PWR_SR_RECOVERY)
      illegal_cmd <= cke_prev_ff && !is_quiet; // see R03
    else if (run && is_mrs)
      illegal_cmd <= !both_idle;
    else
      illegal_cmd <= 1'b0;
  end

  // Per-bank state: a command on the other bank may end this bank's burst
  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    always_ff @(posedge clock)
    begin
      if (srst)
      begin
        bank_ff[b] <= scbc_pkg::BANK_IDLE;
        row_addr[b] <= '0;
      end
      else if (run && !is_nop) // see R12
      begin
        if (is_act && sel == 1'(b) && bank_ff[b] == scbc_pkg::BANK_IDLE)
        begin
          bank_ff[b] <= scbc_pkg::BANK_ACTIVE; // see R15
          row_addr[b] <= cmd.addr[`SCBC_ROW_BITS-1:0];
        end
        else if ((is_rd || is_wr) && bank_ff[b] != scbc_pkg::BANK_IDLE)
        begin
          if (sel == 1'(b))
          begin
            if (is_rd)
              bank_ff[b] <= cmd.addr[`SCBC_AP_BIT] ? scbc_pkg::BANK_READ_AP
                                                  : scbc_pkg::BANK_READ; // see R13
            else
              bank_ff[b] <= cmd.addr[`SCBC_AP_BIT] ? scbc_pkg::BANK_WRITE_AP
                                                  : scbc_pkg::BANK_WRITE; // see R14
          end
          else
            bank_ff[b] <= scbc_pkg::BANK_ACTIVE; // see R13, auto-precharge bursts cut too
        end
        else if (is_pre && (cmd.addr[`SCBC_AP_BIT] || sel == 1'(b)))
          bank_ff[b] <= scbc_pkg::BANK_IDLE; // see R16
        else if (is_bst && (bank_ff[b] == scbc_pkg::BANK_READ ||
                            bank_ff[b] == scbc_pkg::BANK_WRITE))
          bank_ff[b] <= scbc_pkg::BANK_ACTIVE; // see R16
      end
    end
  end

  // Column latch and mode-set pulse; the mode word is not kept, nothing here reads it
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      col_addr <= '0;
      mode_set_pulse <= 1'b0;
    end
    else
    begin
      mode_set_pulse <= run && is_mrs && both_idle; // see R06
      if (run && (is_rd || is_wr))
        col_addr <= cmd.addr[`SCBC_COL_BITS-1:0]; // see R17
    end
  end

  // Registered status copies of internal state
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bank_idle <= 2'h3;
      bank_active <= 2'h0;
      bank_reading <= 2'h0;
      bank_writing <= 2'h0;
      bank_autoprecharge <= 2'h0;
      self_refresh <= 1'b0;
      power_down <= 1'b0;
      clock_suspended <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        bank_idle[i] <= bank_ff[i] == scbc_pkg::BANK_IDLE;
        bank_active[i] <= bank_ff[i] == scbc_pkg::BANK_ACTIVE;
        bank_reading[i] <= bank_ff[i] inside {scbc_pkg::BANK_READ, scbc_pkg::BANK_READ_AP};
        bank_writing[i] <= bank_ff[i] inside {scbc_pkg::BANK_WRITE, scbc_pkg::BANK_WRITE_AP};
        bank_autoprecharge[i] <= bank_ff[i] inside {scbc_pkg::BANK_READ_AP,
                                                    scbc_pkg::BANK_WRITE_AP};
      end
      self_refresh <= pwr_ff == scbc_pkg::PWR_SELF_REFRESH;
      power_down <= pwr_ff == scbc_pkg::PWR_POWER_DOWN;
      clock_suspended <= pwr_ff == scbc_pkg::PWR_SUSPEND;
    end
  end

  a_sr_entry: assert property (@(posedge clock) disable iff (srst) // see R05
    (pwr_ff == scbc_pkg::PWR_NORMAL && both_idle && cke_prev_ff && !cke && is_ref)
    |=> pwr_ff == scbc_pkg::PWR_SELF_REFRESH) else $error("self-refresh not entered");
  a_sr_hold: assert property (@(posedge clock) disable iff (srst) // see R01
    (pwr_ff == scbc_pkg::PWR_SELF_REFRESH && !cke) |=> pwr_ff == scbc_pkg::PWR_SELF_REFRESH)
    else $error("self-refresh left while enable low");
  a_pd_exit: assert property (@(posedge clock) disable iff (srst) // see R04
    (pwr_ff == scbc_pkg::PWR_POWER_DOWN && !cke_prev_ff && cke) |=> pwr_ff == scbc_pkg::PWR_NORMAL)
    else $error("power-down not ended");
  a_rec_pd: assert property (@(posedge clock) disable iff (srst) // see R03
    (pwr_ff == scbc_pkg::PWR_SR_RECOVERY && cke_prev_ff && !cke && is_nop)
    |=> pwr_ff == scbc_pkg::PWR_POWER_DOWN) else $error("recovery to power-down missed");
  a_suspend_in: assert property (@(posedge clock) disable iff (srst) // see R08
    (pwr_ff == scbc_pkg::PWR_NORMAL && !both_idle && cke_prev_ff && !cke)
    |=> pwr_ff == scbc_pkg::PWR_SUSPEND)
    else $error("suspend not entered");
  a_suspend_out: assert property (@(posedge clock) disable iff (srst) // see R09
    (pwr_ff == scbc_pkg::PWR_SUSPEND && cke) |=> pwr_ff == scbc_pkg::PWR_NORMAL)
    else $error("suspend not ended");
  a_act_bank: assert property (@(posedge clock) disable iff (srst) // see R15
    (run && is_act && !sel && bank_ff[0] == scbc_pkg::BANK_IDLE)
    |=> bank_ff[0] == scbc_pkg::BANK_ACTIVE &&
    row_addr[0] == $past(cmd.addr[`SCBC_ROW_BITS-1:0]))
    else $error("activate bank 0 failed");
  a_pre_all: assert property (@(posedge clock) disable iff (srst) // see R16
    (run && is_pre && cmd.addr[`SCBC_AP_BIT]) |=> both_idle) else $error("precharge all failed");
  a_nop_keep: assert property (@(posedge clock) disable iff (srst) // see R12
    (run && is_nop) |=> $stable(bank_ff[1]) && $stable(bank_ff[0]))
    else $error("bank changed on nop");
  a_rd_ap: assert property (@(posedge clock) disable iff (srst) // see R13
    (run && is_rd && sel && cmd.addr[`SCBC_AP_BIT] && bank_ff[1] != scbc_pkg::BANK_IDLE)
    |=> bank_ff[1] == scbc_pkg::BANK_READ_AP) else $error("read-ap bank 1 failed");
  a_col_low: assert property (@(posedge clock) disable iff (srst) // see R17
    (run && is_wr) |=> col_addr == $past(cmd.addr[`SCBC_COL_BITS-1:0]))
    else $error("column latch wrong");
endmodule
`default_nettype wire

// file: scbc_ctrl_tb.sv
// Self-checking bench for the SDRAM clock-enable and bank state block
`timescale 1ns/100ps
`default_nettype none
module scbc_ctrl_tb;
  logic clock;
  logic srst;
  logic cke;
  scbc_pkg::scbc_cmd_s cmd;
  logic [1:0] bi, ba, br, bw, bp;
  logic sr, pd, cs, mp, ill;
  logic [10:0] row_addr [2];
  logic [7:0] col_addr;
  int failures = 0;
  int n_compared = 0;
  int n_ill = 0;
  int n_mrs = 0;
  int cycles = 0;
  scbc_host_model h (.clock(clock), .cke(cke), .cmd(cmd));
  scbc_ctrl #(.ROW_WAIT(2)) uut (.clock(clock), .srst(srst), .cke(cke), .cmd(cmd),
    .bank_idle(bi), .bank_active(ba), .bank_reading(br), .bank_writing(bw),
    .bank_autoprecharge(bp), .self_refresh(sr), .power_down(pd), .clock_suspended(cs),
    .mode_set_pulse(mp), .illegal_cmd(ill), .row_addr(row_addr), .col_addr(col_addr));
  // Clock at 25 MHz
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Pulse counters and hang guard; pulses last a single cycle
  always @(posedge clock)
  begin
    n_ill += (ill === 1'b1);
    n_mrs += (mp === 1'b1);
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Let the sampled command reach the registered outputs
  task automatic settle(input logic ke);
    h.idle(1, ke);
    @(posedge clock);
    #1;
  endtask
  task automatic t_reset();
    check("idle", bi, 2'h3);
    check("modes", {sr, pd, cs}, 3'h0);
    check("row0", row_addr[0], 11'h000);
    $display("test reset done");
  endtask
  task automatic t_banks();
    h.op(4'h3, 12'h123, 1'b1);
    h.op(4'h3, 12'haaa, 1'b1);
    settle(1'b1);
    check("active", ba, 2'h3);
    check("row0", row_addr[0], 11'h123);
    check("row1", row_addr[1], 11'h2aa);
    h.op(4'h5, 12'h7a5, 1'b1);
    settle(1'b1);
    check("reading", {br, bp}, 4'h5);
    check("col", col_addr, 8'ha5);
    h.op(4'h4, 12'h8c3, 1'b1);
    h.op(4'h6, 12'h000, 1'b1);
    h.op(4'h4, 12'hcc3, 1'b1);
    settle(1'b1);
    check("write", {bw, bp, br, ba}, 8'ha1);
    h.op(4'h2, 12'h800, 1'b1);
    settle(1'b1);
    check("pre one", {bi, ba}, 4'h9);
    h.op(4'h2, 12'h400, 1'b1);
    settle(1'b1);
    check("pre all", bi, 2'h3);
    $display("test banks done");
  endtask
  task automatic t_mode();
    h.op(4'h0, 12'h023, 1'b1);
    h.idle(3, 1'b1);
    check("mode set", n_mrs, 1);
    h.op(4'h3, 12'h001, 1'b1);
    h.put(4'h0, 12'h023, 1'b1);
    h.idle(4, 1'b1);
    check("busy set", {n_mrs[3:0], n_ill[3:0]}, 8'h11);
    h.op(4'h2, 12'h400, 1'b1);
    $display("test mode done");
  endtask
  task automatic t_power();
    h.op(4'h1, 12'h000, 1'b0);
    h.idle(3, 1'b0);
    check("self", {sr, pd}, 2'h2);
    h.wake();
    h.idle(3, 1'b1);
    check("left self", {sr, bi}, 3'h3);
    h.op(4'h1, 12'h000, 1'b0);
    h.idle(2, 1'b0);
    h.put(4'h7, 12'h000, 1'b1);
    h.put(4'h7, 12'h000, 1'b0);
    h.idle(3, 1'b0);
    check("rec down", pd, 1'b1);
    h.wake();
    h.idle(2, 1'b1);
    check("down exit", {pd, bi}, 3'h3);
    h.put(4'h7, 12'h000, 1'b0);
    h.idle(3, 1'b0);
    check("idle down", pd, 1'b1);
    h.wake();
    h.op(4'h1, 12'h000, 1'b0);
    h.idle(2, 1'b0);
    h.put(4'h7, 12'h000, 1'b1);
    h.put(4'h5, 12'h000, 1'b1);
    h.idle(4, 1'b1);
    check("rec read", n_ill, 2);
    $display("test power done");
  endtask
  task automatic t_suspend();
    h.op(4'h3, 12'h001, 1'b1);
    h.op(4'h7, 12'h000, 1'b0);
    h.idle(3, 1'b0);
    check("suspend", cs, 1'b1);
    h.put(4'h2, 12'h400, 1'b0);
    h.idle(2, 1'b0);
    check("frozen", ba, 2'h1);
    h.put(4'h7, 12'h000, 1'b1);
    h.op(4'h2, 12'h400, 1'b1);
    settle(1'b1);
    check("resume", {cs, bi}, 3'h3);
    $display("test suspend done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Reset for four cycles, enable high two edges, then the scenarios
  initial
  begin
    srst = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    srst = 1'b0;
    t_reset();
    h.idle(2, 1'b1);
    t_banks();
    t_mode();
    t_suspend();
    t_power();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: scbc_host_model.sv
// Memory-controller stand-in that drives clock enable and the command pins
`timescale 1ns/100ps
`default_nettype none
module scbc_host_model
(
  input wire logic clock,
  output logic cke,
  output scbc_pkg::scbc_cmd_s cmd
);
  logic [1:0] open_b; // Own copy of banks with an open row
  // Start deselected with enable low, as at power-up
  initial
  begin
    cke = 1'b0;
    cmd = 16'hf000;
    open_b = 2'h0;
  end
  // One command per edge, held until the next edge has sampled it
  task automatic put(input logic [3:0] code, input logic [11:0] a, input logic ke);
    @(posedge clock);
    #1;
    cke = ke;
    cmd = {code, a};
  endtask
  // Deselect moves the address so stale values never look held
  task automatic idle(input int n, input logic ke);
    repeat (n)
      put(4'hf, ~cmd.addr, ke);
  endtask
  // Mode set only with no open row, other commands pass unchecked; bank copy kept current, mode set padded
  task automatic op(input logic [3:0] code, input logic [11:0] a, input logic ke);
    if (code == 4'h3)
      open_b[a[11]] = 1'b1;
    if (code == 4'h2 && a[10])
      open_b = 2'h0;
    else if (code == 4'h2)
      open_b[a[11]] = 1'b0;
    if (code == 4'h0 && open_b != 2'h0)
      code = 4'hf;
    put(code, a, ke);
    if (code == 4'h0)
      idle(2, ke);
  endtask
  // Wake with a no-operation, then one setup cycle before real commands
  task automatic wake();
    put(4'h7, 12'h000, 1'b1);
    idle(1, 1'b1);
  endtask
endmodule
`default_nettype wire

// file: scbc_pkg.sv
// Types for the SDRAM clock-enable and bank state control block
package scbc_pkg;
  typedef enum logic [5:0] {
    BANK_IDLE = 6'h01,
    BANK_ACTIVE = 6'h02,
    BANK_READ = 6'h04,
    BANK_WRITE = 6'h08,
    BANK_READ_AP = 6'h10,
    BANK_WRITE_AP = 6'h20
  } scbc_bank_e;
  typedef enum logic [4:0] {
    PWR_NORMAL = 5'h01,
    PWR_SELF_REFRESH = 5'h02,
    PWR_SR_RECOVERY = 5'h04,
    PWR_POWER_DOWN = 5'h08,
    PWR_SUSPEND = 5'h10
  } scbc_pwr_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [11:0] addr;
  } scbc_cmd_s;
endpackage
